// ===== verilog/tkr_pkg.sv
package tkr_pkg;

  // Key array
  localparam int unsigned KEYS = 48;

  // Command codes
  localparam logic [7:0] CMD_NULL    = 8'h00;
  localparam logic [7:0] CMD_RESET   = 8'h04;
  localparam logic [7:0] CMD_STATUS  = 8'h05;
  localparam logic [7:0] CMD_FIRST   = 8'h06;
  localparam logic [7:0] CMD_ALLKEYS = 8'h07;
  localparam logic [7:0] CMD_SIGNALS = 8'h08;
  localparam logic [7:0] CMD_REFS    = 8'h09;
  localparam logic [7:0] CMD_DELTAS  = 8'h0A;
  localparam logic [7:0] CMD_ERRS    = 8'h0B;
  localparam logic [7:0] CMD_LINES   = 8'h0C;
  localparam logic [7:0] CMD_LAST    = 8'h0F;

  // Fixed reply values
  localparam logic [7:0] RESET_ACK = 8'hFB;
  localparam logic [5:0] NO_KEY    = 6'h3F;

  // General status byte layout
  localparam int unsigned ST_COMM_BIT   = 6;
  localparam int unsigned ST_FMEA_BIT   = 5;
  localparam int unsigned ST_EEPROM_BIT = 4;
  localparam int unsigned ST_SYNC_BIT   = 3;
  localparam int unsigned ST_CALF_BIT   = 2;
  localparam int unsigned ST_CAL_BIT    = 1;
  localparam int unsigned ST_DET_BIT    = 0;

  // First-key byte layout
  localparam int unsigned FK_MULTI_BIT = 7;
  localparam int unsigned FK_FLAG_BIT  = 6;

  // Reply data lengths in bytes, check byte excluded
  localparam logic [6:0] LEN_ONE   = 7'h01;
  localparam logic [6:0] LEN_FIELD = 7'h06;
  localparam logic [6:0] LEN_WORDS = 7'h60;
  localparam logic [6:0] LEN_BYTES = 7'h30;

  // Check byte defaults, shared with the host
  localparam logic [7:0] CRC_POLY_DEF = 8'h07;
  localparam logic [7:0] CRC_INIT_DEF = 8'h00;

  // Timing
  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned DBL_WINDOW_MS  = 100;
  localparam int unsigned DBL_WINDOW_CYC = DBL_WINDOW_MS * (CLK_HZ / 1000);
  localparam int unsigned TMR_W          = 22;

  // Reply sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_SEND = 2'b10
  } tkr_state_t;

  // Codes that this block answers or acts on
  function automatic logic is_known(input logic [7:0] c);
    return (c >= CMD_RESET && c <= CMD_LINES) || c == CMD_LAST;
  endfunction

  // Number of data bytes before the check byte
  function automatic logic [6:0] data_len(input logic [7:0] c);
    unique case (c)
      CMD_ALLKEYS, CMD_ERRS:  data_len = LEN_FIELD;
      CMD_SIGNALS, CMD_REFS:  data_len = LEN_WORDS;
      CMD_DELTAS:             data_len = LEN_BYTES;
      default:                data_len = LEN_ONE;
    endcase
  endfunction

  // Replies that end in a check byte
  function automatic logic has_crc(input logic [7:0] c);
    return c == CMD_STATUS || c == CMD_FIRST || c == CMD_ALLKEYS ||
           c == CMD_ERRS || c == CMD_LINES;
  endfunction

endpackage

// ===== verilog/tkr_crc_if.sv
`timescale 1ns/100ps
interface tkr_crc_if;
  logic       init;
  logic       upd;
  logic [7:0] din;
  logic [7:0] crc;

  modport calc (input init, input upd, input din, output crc);
  modport user (output init, output upd, output din, input crc);
endinterface

// ===== verilog/tkr_crc8.sv
`timescale 1ns/100ps
module tkr_crc8 #(
  parameter logic [7:0] POLY = tkr_pkg::CRC_POLY_DEF,
  parameter logic [7:0] INIT = tkr_pkg::CRC_INIT_DEF
) (
  input  wire logic   ref_clk_i,
  input  wire logic   rst_n_i,
  tkr_crc_if.calc     crc_c
);

  logic [7:0] crc_q;

  // One byte, MSB first, through the polynomial
  function automatic logic [7:0] step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ POLY) : (r << 1);
    end
    return r;
  endfunction

  // Init restarts from the seed with the command byte folded in
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crc_q <= 8'h00;
    end else if (crc_c.init) begin
      crc_q <= step(INIT, crc_c.din);
    end else if (crc_c.upd) begin
      crc_q <= step(crc_q, crc_c.din);
    end
  end

  assign crc_c.crc = crc_q;

endmodule

// ===== verilog/tkr_first_key.sv
`timescale 1ns/100ps
module tkr_first_key #(
  parameter int unsigned KEYS = tkr_pkg::KEYS
) (
  input  wire logic [KEYS-1:0] detect_i,
  output logic      [5:0]      first_o,
  output logic                 multi_o
);

  if (KEYS < 2 || KEYS > 63) begin : g_bad_keys
    $error("KEYS must leave 0x3F free");
  end

  // Lowest numbered touched key wins; scan from the top so it lands last
  always_comb begin
    first_o = tkr_pkg::NO_KEY;
    for (int k = KEYS - 1; k >= 0; k--) begin
      if (detect_i[k]) first_o = 6'(k);
    end
  end

  // Clearing the lowest set bit leaves something only for two or more touches
  assign multi_o = |(detect_i & (detect_i - 1'b1));

endmodule

// ===== verilog/tkr_responder.sv
// What this block does
// - Reset needs two back-to-back codes within window
// - Accepted reset answers 0xFB, then resets
// - Missing second copy: abandon silently
// - Status reply: status byte plus check byte
// - Status bit6 unknown command, bit7 reserved
// - Comms error holds until last-command code
// - Status bits 5,4,3: fault, store, sync
// - Status bit2: calibration failure or low reference
// - Status bit1 calibrating, bit0 any detect
// - First-key bit7 flags multiple touches, check byte
// - First-key bit6 flags calibrating or any status-byte error except low reference
// - First-key low bits key number, 0x3F none
// - All-keys: six detect bytes plus check
// - Signals: 48 words, low byte first, unchecked
// - References: 48 words, low byte first, unchecked
// - Deltas: reference minus signal, clamped, unchecked
// - Error flags: six bytes plus check byte
// - Line faults: one byte plus check byte
// - Last-command returns complement of last code
`timescale 1ns/100ps
module tkr_responder #(
  parameter int unsigned WINDOW_CYC = tkr_pkg::DBL_WINDOW_CYC,
  parameter logic [7:0]  CRC_POLY   = tkr_pkg::CRC_POLY_DEF,
  parameter logic [7:0]  CRC_INIT   = tkr_pkg::CRC_INIT_DEF
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        cmd_valid_i,
  input  wire logic [7:0]  cmd_byte_i,
  output logic             cmd_ready_o,
  output logic             rsp_valid_o,
  output logic      [7:0]  rsp_byte_o,
  input  wire logic        rsp_ready_i,
  input  wire logic [47:0] key_detect_i,
  input  wire logic [47:0] key_err_i,
  input  wire logic        any_cal_i,
  input  wire logic        cal_fail5_i,
  input  wire logic        low_ref_i,
  input  wire logic        fmea_fail_i,
  input  wire logic        eeprom_bad_i,
  input  wire logic        sync_fail_i,
  input  wire logic [7:0]  line_fault_i,
  output logic      [5:0]  key_sel_o,
  input  wire logic [15:0] key_sig_i,
  input  wire logic [15:0] key_ref_i,
  output logic             comm_err_o,
  output logic             soft_reset_o
);

  localparam int unsigned TW = tkr_pkg::TMR_W;

  if (WINDOW_CYC < 1 || WINDOW_CYC >= (1 << TW)) begin : g_bad_window
    $error("WINDOW_CYC out of range");
  end

  tkr_pkg::tkr_state_t state_q;
  logic [7:0]    cmd_q;
  logic [7:0]    last_q;
  logic [6:0]    idx_q;
  logic [6:0]    len_q;
  logic          crc_en_q;
  logic          arm_q;
  logic [TW-1:0] tmr_q;
  logic          comm_err_q;
  logic          rst_pend_q;
  logic          soft_reset_q;
  logic [7:0]    byte_q;
  logic          accept;
  logic          real_cmd;
  logic          fire;
  logic          start;
  logic          crc_slot;
  logic          last_hs;
  logic [7:0]    data_byte;
  logic [7:0]    status_byte;
  logic [7:0]    first_byte;
  logic [5:0]    first_key;
  logic          multi_touch;

  tkr_crc_if crc_c ();

  tkr_crc8 #(
    .POLY (CRC_POLY),
    .INIT (CRC_INIT)
  ) u_crc (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .crc_c     (crc_c.calc)
  );

  tkr_first_key #(
    .KEYS (tkr_pkg::KEYS)
  ) u_first (
    .detect_i (key_detect_i),
    .first_o  (first_key),
    .multi_o  (multi_touch)
  );

  // Clamp reference minus signal into one unsigned byte
  function automatic logic [7:0] delta(input logic [15:0] r, input logic [15:0] s);
    logic [15:0] d;
    d = r - s;
    if (r < s) return 8'h00;
    if (d > 16'h00FF) return 8'hFF;
    return d[7:0];
  endfunction

  // Commands are taken only between replies; nulls are taken here and dropped
  assign cmd_ready_o = (state_q == tkr_pkg::ST_IDLE);
  assign accept      = cmd_valid_i && cmd_ready_o;
  assign real_cmd    = accept && (cmd_byte_i != tkr_pkg::CMD_NULL);
  assign fire        = real_cmd && (cmd_byte_i == tkr_pkg::CMD_RESET) && arm_q;
  assign start       = real_cmd && tkr_pkg::is_known(cmd_byte_i) &&
                       (cmd_byte_i != tkr_pkg::CMD_RESET || arm_q);
  assign crc_slot    = crc_en_q && (idx_q == len_q);
  assign last_hs     = (state_q == tkr_pkg::ST_SEND) && rsp_ready_i &&
                       (idx_q == len_q - {6'h00, !crc_en_q});

  // Double-issue guard: first copy arms, any other non-null command disarms
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arm_q <= 1'b0;
      tmr_q <= '0;
    end else if (real_cmd) begin
      arm_q <= (cmd_byte_i == tkr_pkg::CMD_RESET) && !arm_q;
      tmr_q <= TW'(WINDOW_CYC - 1);
    end else if (arm_q) begin
      if (tmr_q == '0) begin
        arm_q <= 1'b0;
      end
      tmr_q <= tmr_q - 1'b1;
    end
  end

  // Last code seen, kept even if unknown; the query code itself is not kept
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      last_q <= 8'h00;
    end else if (real_cmd && cmd_byte_i != tkr_pkg::CMD_LAST) begin
      last_q <= cmd_byte_i;
    end
  end

  // Sticky comms error; one command per cycle, so set and clear never meet
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      comm_err_q <= 1'b0;
    end else if (real_cmd && !tkr_pkg::is_known(cmd_byte_i)) begin
      comm_err_q <= 1'b1;
    end else if (real_cmd && cmd_byte_i == tkr_pkg::CMD_LAST) begin
      comm_err_q <= 1'b0;
    end
  end

  // Reset is held back until the acknowledge byte has left
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_pend_q   <= 1'b0;
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= rst_pend_q && last_hs;
      if (fire) begin
        rst_pend_q <= 1'b1;
      end else if (last_hs) begin
        rst_pend_q <= 1'b0;
      end
    end
  end

  // Status and first-key bytes built from live sensing state
  always_comb begin
    status_byte = 8'h00;
    status_byte[tkr_pkg::ST_COMM_BIT]   = comm_err_q;
    status_byte[tkr_pkg::ST_FMEA_BIT]   = fmea_fail_i;
    status_byte[tkr_pkg::ST_EEPROM_BIT] = eeprom_bad_i;
    status_byte[tkr_pkg::ST_SYNC_BIT]   = sync_fail_i;
    status_byte[tkr_pkg::ST_CALF_BIT]   = cal_fail5_i || low_ref_i;
    status_byte[tkr_pkg::ST_CAL_BIT]    = any_cal_i;
    status_byte[tkr_pkg::ST_DET_BIT]    = |key_detect_i;
    first_byte = {2'b00, first_key};
    first_byte[tkr_pkg::FK_MULTI_BIT] = multi_touch;
    first_byte[tkr_pkg::FK_FLAG_BIT]  = any_cal_i || cal_fail5_i || sync_fail_i ||
                                        comm_err_q || fmea_fail_i || eeprom_bad_i;
  end

  // Word dumps address key idx/2; delta dump addresses key idx
  assign key_sel_o = (cmd_q == tkr_pkg::CMD_DELTAS) ? idx_q[5:0] : idx_q[6:1];

  // Byte for the current reply position
  always_comb begin
    unique case (cmd_q)
      tkr_pkg::CMD_RESET:   data_byte = tkr_pkg::RESET_ACK;
      tkr_pkg::CMD_STATUS:  data_byte = status_byte;
      tkr_pkg::CMD_FIRST:   data_byte = first_byte;
      tkr_pkg::CMD_ALLKEYS: data_byte = key_detect_i[{idx_q[2:0], 3'b000} +: 8];
      tkr_pkg::CMD_SIGNALS: data_byte = idx_q[0] ? key_sig_i[15:8] : key_sig_i[7:0];
      tkr_pkg::CMD_REFS:    data_byte = idx_q[0] ? key_ref_i[15:8] : key_ref_i[7:0];
      tkr_pkg::CMD_DELTAS:  data_byte = delta(key_ref_i, key_sig_i);
      tkr_pkg::CMD_ERRS:    data_byte = key_err_i[{idx_q[2:0], 3'b000} +: 8];
      tkr_pkg::CMD_LINES:   data_byte = line_fault_i;
      tkr_pkg::CMD_LAST:    data_byte = ~last_q;
      default:              data_byte = 8'h00;
    endcase
  end

  // Check byte covers the command and every data byte before it
  assign crc_c.init = start;
  assign crc_c.upd  = (state_q == tkr_pkg::ST_LOAD) && !crc_slot;
  assign crc_c.din  = start ? cmd_byte_i : data_byte;

  // Reply sequencer: one load cycle per byte keeps the output registered
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q  <= tkr_pkg::ST_IDLE;
      cmd_q    <= 8'h00;
      idx_q    <= 7'h00;
      len_q    <= 7'h00;
      crc_en_q <= 1'b0;
      byte_q   <= 8'h00;
    end else begin
      unique case (state_q)
        tkr_pkg::ST_IDLE: begin
          if (start) begin
            cmd_q    <= cmd_byte_i;
            idx_q    <= 7'h00;
            len_q    <= tkr_pkg::data_len(cmd_byte_i);
            crc_en_q <= tkr_pkg::has_crc(cmd_byte_i);
            state_q  <= tkr_pkg::ST_LOAD;
          end
        end
        tkr_pkg::ST_LOAD: begin
          byte_q  <= crc_slot ? crc_c.crc : data_byte;
          state_q <= tkr_pkg::ST_SEND;
        end
        tkr_pkg::ST_SEND: begin
          if (rsp_ready_i) begin
            idx_q   <= idx_q + 1'b1;
            state_q <= last_hs ? tkr_pkg::ST_IDLE : tkr_pkg::ST_LOAD;
          end
        end
        default: state_q <= tkr_pkg::ST_IDLE;
      endcase
    end
  end

  assign rsp_valid_o  = (state_q == tkr_pkg::ST_SEND);
  assign rsp_byte_o   = byte_q;
  assign comm_err_o   = comm_err_q;
  assign soft_reset_o = soft_reset_q;

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_load_first;
    state_q == tkr_pkg::ST_LOAD && idx_q == 7'h00;
  endsequence

  sequence s_shown(logic [7:0] b);
    ##1 rsp_valid_o && rsp_byte_o == b;
  endsequence

  a_reset_ack_out: assert property (
    fire |-> ##1 s_shown(tkr_pkg::RESET_ACK))
    else $error("reset acknowledge not sent");

  a_single_reset_mute: assert property (
    (real_cmd && cmd_byte_i == tkr_pkg::CMD_RESET && !arm_q) |=> !rsp_valid_o[*3])
    else $error("single reset code answered");

  a_window_lapse: assert property (
    (arm_q && tmr_q == '0 && !real_cmd) |=> !arm_q ##1 !rsp_valid_o)
    else $error("reset window did not lapse");

  a_reset_after_ack: assert property (
    (rst_pend_q && last_hs) |=> soft_reset_o ##1 !soft_reset_o)
    else $error("soft reset not pulsed after acknowledge");

  a_status_bits: assert property (
    (s_load_first and cmd_q == tkr_pkg::CMD_STATUS) |=>
      rsp_byte_o[7] == 1'b0 && rsp_byte_o[6] == $past(comm_err_q) &&
      rsp_byte_o[2] == $past(cal_fail5_i || low_ref_i))
    else $error("status byte wrong");

  a_first_none: assert property (
    (s_load_first and cmd_q == tkr_pkg::CMD_FIRST && key_detect_i == '0) |=>
      rsp_byte_o[5:0] == tkr_pkg::NO_KEY && !rsp_byte_o[7])
    else $error("no-touch key number wrong");

  a_sig_low_first: assert property (
    (state_q == tkr_pkg::ST_LOAD && cmd_q == tkr_pkg::CMD_SIGNALS && !idx_q[0]) |=>
      rsp_byte_o == $past(key_sig_i[7:0]))
    else $error("signal word not low byte first");

  a_delta_clamp: assert property (
    (state_q == tkr_pkg::ST_LOAD && cmd_q == tkr_pkg::CMD_DELTAS &&
     key_ref_i < key_sig_i) |=> rsp_byte_o == 8'h00)
    else $error("negative delta not clamped");

  a_crc_tail: assert property (
    (state_q == tkr_pkg::ST_LOAD && crc_slot) |=> rsp_byte_o == $past(crc_c.crc))
    else $error("check byte wrong");

  a_unknown_err: assert property (
    (real_cmd && !tkr_pkg::is_known(cmd_byte_i)) |=> comm_err_o && state_q == tkr_pkg::ST_IDLE)
    else $error("unknown code handled wrongly");

  a_last_clears: assert property (
    (real_cmd && cmd_byte_i == tkr_pkg::CMD_LAST) |-> ##1 !comm_err_o ##1 rsp_byte_o == ~last_q)
    else $error("last-command reply or clear wrong");

endmodule

// ===== tb/tkr_host_model.sv
`timescale 1ns/100ps
module tkr_host_model (
  input  wire logic       ref_clk_i,
  input  wire logic       cmd_ready_i,
  input  wire logic       rsp_valid_i,
  input  wire logic [7:0] rsp_byte_i,
  output logic            cmd_valid_o,
  output logic      [7:0] cmd_byte_o,
  output logic            rsp_ready_o
);
  logic [7:0] rx_q[$];
  int         stall_pct;
  int         seed;

  // Idle host: bus released, nothing requested
  initial begin
    cmd_valid_o = 1'b0;
    cmd_byte_o  = 8'hA5;
    rsp_ready_o = 1'b0;
    stall_pct   = 0;
    seed        = 98893;
  end

  // One command, then pull n reply bytes with random stalls
  task automatic send(input logic [7:0] c, input int n);
    int hang;
    hang = 0;
    rx_q.delete();
    @(negedge ref_clk_i);
    while (cmd_ready_i !== 1'b1 && hang < 500) begin
      hang++;
      @(negedge ref_clk_i);
    end
    cmd_byte_o  = c;
    cmd_valid_o = 1'b1;
    @(negedge ref_clk_i);
    cmd_valid_o = 1'b0;
    cmd_byte_o  = ~c; // Released bus must not look like a held code
    hang        = 0;  // A slow ready must not cut the reply loop short
    // Keep pulling a few cycles past n so extra bytes get caught
    while (hang < 6) begin
      rsp_ready_o = (rx_q.size() >= n) || (($random(seed) & 127) >= stall_pct);
      if (rsp_ready_o && rsp_valid_i === 1'b1) rx_q.push_back(rsp_byte_i);
      if (rx_q.size() >= n) hang++;
      @(negedge ref_clk_i);
    end
    rsp_ready_o = 1'b0;
  endtask
endmodule

// ===== tb/test_touch_key_status_command_responder.sv
`timescale 1ns/100ps
module test_touch_key_status_command_responder;
  localparam int WIN = 20;
  logic        ref_clk_i;
  logic        rst_n_i;
  logic        cmd_valid;
  logic [7:0]  cmd_byte;
  logic        cmd_ready;
  logic        rsp_valid;
  logic [7:0]  rsp_byte;
  logic        rsp_ready;
  logic [47:0] det;
  logic [47:0] kerr;
  logic [5:0]  flg;
  logic [7:0]  line;
  logic [5:0]  key_sel;
  logic        comm_err;
  logic        soft_reset;
  logic [15:0] sig_a[64];
  logic [15:0] ref_a[64];
  int          error_cnt;
  int          checks;
  int          seed;
  int          cyc;
  int          pulses;
  int          exp_pulses;
  int          comm;
  int          armed;
  int          arm_cyc;
  logic [7:0]  last;
  logic [7:0]  unk[5] = '{8'h01, 8'h0D, 8'h20, 8'hFF, 8'h00};

  tkr_responder #(.WINDOW_CYC(WIN)) u_dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid),
    .cmd_byte_i(cmd_byte), .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid),
    .rsp_byte_o(rsp_byte), .rsp_ready_i(rsp_ready), .key_detect_i(det),
    .key_err_i(kerr), .any_cal_i(flg[0]), .cal_fail5_i(flg[1]), .low_ref_i(flg[2]),
    .fmea_fail_i(flg[3]), .eeprom_bad_i(flg[4]), .sync_fail_i(flg[5]),
    .line_fault_i(line), .key_sel_o(key_sel), .key_sig_i(sig_a[key_sel]),
    .key_ref_i(ref_a[key_sel]), .comm_err_o(comm_err), .soft_reset_o(soft_reset)
  );

  tkr_host_model u_host (
    .ref_clk_i(ref_clk_i), .cmd_ready_i(cmd_ready), .rsp_valid_i(rsp_valid),
    .rsp_byte_i(rsp_byte), .cmd_valid_o(cmd_valid), .cmd_byte_o(cmd_byte),
    .rsp_ready_o(rsp_ready)
  );

  // 25 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end

  // Cycle count, pulse count and hang guard
  always @(posedge ref_clk_i) begin
    cyc++;
    if (soft_reset === 1'b1) pulses++;
    if (cyc > 30000) begin
      error_cnt++;
      $display("MISMATCH timeout expected finish seen hang");
      end_of_test();
    end
  end

  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  // Check byte: MSB first, no reflection, seed zero
  function automatic logic [7:0] crc8(input logic [7:0] b[$]);
    logic [7:0] c;
    c = 8'h00;
    foreach (b[i]) begin
      c ^= b[i];
      for (int j = 0; j < 8; j++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // New sensing picture; delta keys mix small, negative and large gaps
  task automatic shuffle(input int r);
    @(negedge ref_clk_i);
    det  = (r % 3 == 0) ? 48'h0 : (r % 3 == 1) ? 48'h1 << (r * 7 % 48) : {$random(seed), $random(seed)};
    kerr = {$random(seed), $random(seed)};
    flg  = (r == 0) ? 6'h00 : 6'($random(seed));
    line = 8'($random(seed));
    for (int k = 0; k < 64; k++) begin
      sig_a[k] = 16'($random(seed));
      ref_a[k] = (k % 3 == 0) ? sig_a[k] + 16'($random(seed) & 'h1FF) : 16'($random(seed));
    end
  endtask

  // Reference model of one exchange, then compare against the host's haul
  task automatic do_cmd(input logic [7:0] c);
    logic [7:0] e[$];
    logic [7:0] q[$];
    int         d;
    int         f;
    f = 63;
    for (int k = 47; k >= 0; k--) if (det[k]) f = k;
    case (c)
      8'h04: if (armed && cyc - arm_cyc < WIN) begin
          e.push_back(tkr_pkg::RESET_ACK);
          armed = 0;
          exp_pulses++;
        end else begin
          armed   = 1;
          arm_cyc = cyc;
        end
      8'h05: e.push_back({1'b0, comm[0], flg[3], flg[4], flg[5], flg[1] | flg[2], flg[0], |det});
      8'h06: e.push_back({$countones(det) > 1, comm[0] | flg[0] | flg[1] | (|flg[5:3]), 6'(f)});
      8'h07: for (int j = 0; j < 6; j++) e.push_back(det[8*j +: 8]);
      8'h0B: for (int j = 0; j < 6; j++) e.push_back(kerr[8*j +: 8]);
      8'h08: for (int k = 0; k < 48; k++) begin
          e.push_back(sig_a[k][7:0]);
          e.push_back(sig_a[k][15:8]);
        end
      8'h09: for (int k = 0; k < 48; k++) begin
          e.push_back(ref_a[k][7:0]);
          e.push_back(ref_a[k][15:8]);
        end
      8'h0A: for (int k = 0; k < 48; k++) begin
          d = int'(ref_a[k]) - int'(sig_a[k]);
          e.push_back(d < 0 ? 8'h00 : d > 255 ? 8'hFF : d[7:0]);
        end
      8'h0C: e.push_back(line);
      8'h0F: begin
          e.push_back(~last);
          comm = 0;
        end
      default: if (c != 8'h00) comm = 1;
    endcase
    if (c != 8'h04 && c != 8'h00) armed = 0;
    if (c != 8'h0F && c != 8'h00) last = c;
    if (c == 8'h05 || c == 8'h06 || c == 8'h07 || c == 8'h0B || c == 8'h0C) begin
      q = e;
      q.push_front(c);
      e.push_back(crc8(q));
    end
    u_host.send(c, e.size());
    check("reply length", u_host.rx_q.size(), e.size());
    // Host asks again after a short reply, except to a reset; the miss above is still counted
    if (u_host.rx_q.size() < e.size() && c != 8'h04) u_host.send(c, e.size());
    foreach (e[i]) if (i < u_host.rx_q.size()) check("reply byte", u_host.rx_q[i], e[i]);
    check("comm error", comm_err, comm);
    check("reset pulses", pulses, exp_pulses);
  endtask

  // Main sequence
  initial begin
    {det, kerr, flg, line, error_cnt, checks, cyc, pulses, exp_pulses, comm, armed} = '0;
    seed    = 98893;
    last    = 8'h00;
    rst_n_i = 1'b0;
    repeat (20) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    check("reset state", {cmd_ready, rsp_valid, comm_err, soft_reset, key_sel}, 32'h200);
    for (int r = 0; r < 4; r++) begin
      shuffle(r);
      u_host.stall_pct = r * 30;
      for (int c = 5; c <= 12; c++) do_cmd(8'(c));
      $display("Round %0d of report commands done", r);
    end
    foreach (unk[i]) begin
      do_cmd(unk[i]);
      do_cmd(8'h05);
      do_cmd(8'h0F);
    end
    do_cmd(8'h0F);
    // An unknown code is still the one that the query returns
    do_cmd(8'h20);
    do_cmd(8'h0F);
    $display("Unknown code and last-command test done");
    do_cmd(8'h04);
    do_cmd(8'h05);
    do_cmd(8'h04);
    do_cmd(8'h04);
    do_cmd(8'h04);
    repeat (2 * WIN) @(negedge ref_clk_i);
    do_cmd(8'h04);
    do_cmd(8'h04);
    $display("Doubled reset test done");
    end_of_test();
  end

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
endmodule
